/* File: common/bmmr_pkg.sv */
`default_nettype none
package bmmr_pkg;
    typedef logic [7:0] bmmr_byte_t;
    typedef logic [5:0] bmmr_addr_t;
    typedef logic [2:0] bmmr_code_t;
    typedef logic [2:0] bmmr_term_t;
endpackage
`default_nettype wire

/* File: common/bmmr_regs.svh */
`ifndef BMMR_REGS_SVH
`define BMMR_REGS_SVH

// ****************************************************************
// register addresses (6-bit command address)
// ****************************************************************
`define BMMR_ADDR_LATENCY      6'h02
`define BMMR_ADDR_CONFIG       6'h08
`define BMMR_ADDR_REFERENCE    6'h0c
`define BMMR_ADDR_REFRESH_MASK 6'h11
`define BMMR_ADDR_TERMINATION  6'h16

// ****************************************************************
// reset values
// ****************************************************************
`define BMMR_RST_LATENCY       8'h00
`define BMMR_RST_REFERENCE     8'h40
`define BMMR_RST_REFRESH_MASK  8'h00
`define BMMR_RST_TERMINATION   8'h00
`define BMMR_RD_UNDEFINED      8'h00

// ****************************************************************
// latency register fields
// ****************************************************************
`define BMMR_LAT_RL_LSB        0
`define BMMR_LAT_WL_LSB        3
`define BMMR_LAT_WLS_BIT       6
`define BMMR_LAT_LEVEL_BIT     7

// ****************************************************************
// reference register fields
// ****************************************************************
`define BMMR_REF_LEVEL_LSB     0
`define BMMR_REF_RANGE_BIT     6
`define BMMR_REF_VARIANT_BIT   7

// ****************************************************************
// termination register fields
// ****************************************************************
`define BMMR_TERM_HOST_LSB     0
`define BMMR_TERM_CK_BIT       3
`define BMMR_TERM_CS_BIT       4
`define BMMR_TERM_CA_BIT       5
`define BMMR_TERM_LOWER_BIT    6
`define BMMR_TERM_UPPER_BIT    7

// ****************************************************************
// configuration register content
// ****************************************************************
`define BMMR_CFG_TYPE          2'h0
`define BMMR_CFG_WIDTH         2'h1
`define BMMR_CFG_DENSITY       4'h6
`define BMMR_DENS_2GB          4'h0
`define BMMR_DENS_3GB          4'h1
`define BMMR_DENS_4GB          4'h2
`define BMMR_DENS_6GB          4'h3
`define BMMR_DENS_8GB          4'h4
`define BMMR_DENS_12GB         4'h5
`define BMMR_DENS_16GB         4'h6
`define BMMR_SEG_LSB_SMALL     12
`define BMMR_SEG_LSB_MID       13
`define BMMR_SEG_LSB_LARGE     14

// ****************************************************************
// latency tables, entry 7 first, eight bits per entry (clocks)
// ****************************************************************
`define BMMR_RL_PLAIN {8'h28, 8'h24, 8'h20, 8'h1a, 8'h16, 8'h10, 8'h0a, 8'h06}
`define BMMR_RL_INV   {8'h2c, 8'h28, 8'h24, 8'h1e, 8'h18, 8'h12, 8'h0c, 8'h06}
`define BMMR_RTP      {8'h10, 8'h0e, 8'h0c, 8'h0a, 8'h08, 8'h08, 8'h08, 8'h08}
`define BMMR_WL_SET_A {8'h12, 8'h10, 8'h0e, 8'h0c, 8'h0a, 8'h08, 8'h06, 8'h04}
`define BMMR_WL_SET_B {8'h22, 8'h1e, 8'h1a, 8'h16, 8'h12, 8'h0c, 8'h08, 8'h04}
`define BMMR_TBL_ENTRY   8
`define BMMR_RTP_BL32_ADD 8'h08

`endif

/* File: rtl/bmmr_bank.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bmmr_regs.svh"
module bmmr_bank (
    // clock and reset
    input  wire logic                  i_ref_clk,
    input  wire logic                  i_rst_b,
    // register command port
    input  wire logic                  i_cmd_valid,
    input  wire logic                  i_cmd_write,
    input  wire bmmr_pkg::bmmr_addr_t  i_cmd_addr,
    input  wire bmmr_pkg::bmmr_byte_t  i_cmd_data,
    // register read answer
    output logic                       o_rd_valid,
    output bmmr_pkg::bmmr_byte_t       o_rd_data,
    output logic                       o_cmd_ignored,
    // set-point and mode inputs from other registers
    input  wire logic                  i_setpoint_write_select,
    input  wire logic                  i_setpoint_operate_select,
    input  wire logic                  i_read_bus_inversion,
    input  wire logic                  i_burst_32,
    input  wire bmmr_pkg::bmmr_term_t  i_termination_settings,
    // row under refresh
    input  wire logic [17:0]           i_refresh_row,
    // latency outputs
    output logic [7:0]                 o_read_latency,
    output logic [7:0]                 o_read_to_precharge_delay,
    output logic [7:0]                 o_write_latency,
    output logic                       o_write_leveling,
    // reference outputs
    output logic [5:0]                 o_command_reference_level,
    output logic                       o_command_reference_range,
    output logic                       o_command_training_variant,
    // refresh outputs
    output bmmr_pkg::bmmr_byte_t       o_partial_array_refresh,
    output logic                       o_refresh_row_skipped,
    // termination outputs, host value code, lower and upper {cmdaddr, select, clock}
    output bmmr_pkg::bmmr_term_t       o_host_termination_value,
    output bmmr_pkg::bmmr_term_t       o_lower_byte_termination,
    output bmmr_pkg::bmmr_term_t       o_upper_byte_termination
);
    import bmmr_pkg::*;

    // ************************************************************
    // command decode
    // ************************************************************
    logic       write_leveling;
    logic       cmd_accept;
    logic       cmd_wr;
    logic       cmd_rd;
    logic       hit_latency;
    logic       hit_config;
    logic       hit_reference;
    logic       hit_mask;
    logic       hit_termination;
    logic       wr_latency;
    logic       wr_reference;
    logic       wr_mask;
    logic       wr_termination;

    assign hit_latency     = (i_cmd_addr == `BMMR_ADDR_LATENCY);
    assign hit_config      = (i_cmd_addr == `BMMR_ADDR_CONFIG);
    assign hit_reference   = (i_cmd_addr == `BMMR_ADDR_REFERENCE);
    assign hit_mask        = (i_cmd_addr == `BMMR_ADDR_REFRESH_MASK);
    assign hit_termination = (i_cmd_addr == `BMMR_ADDR_TERMINATION);

    // while leveling only a latency write gets through
    assign cmd_accept = i_cmd_valid &&
                        (!write_leveling ||
                         (i_cmd_write && hit_latency));
    assign cmd_wr = cmd_accept && i_cmd_write;
    assign cmd_rd = cmd_accept && !i_cmd_write;

    assign wr_latency     = cmd_wr && hit_latency;
    assign wr_reference   = cmd_wr && hit_reference;
    assign wr_mask        = cmd_wr && hit_mask;
    assign wr_termination = cmd_wr && hit_termination;
    // config writes fall through every decode above

    // ************************************************************
    // set-point register copies
    // ************************************************************
    bmmr_byte_t lat_active;
    bmmr_byte_t ref_active;
    bmmr_byte_t ref_wr_copy;
    bmmr_byte_t mask_active;
    bmmr_byte_t term_active;

    bmmr_setpoint_reg #(.RESET_VALUE(`BMMR_RST_LATENCY)) u_latency (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_wr      (wr_latency),
        .i_wr_sel  (i_setpoint_write_select),
        .i_wr_data (i_cmd_data),
        .i_op_sel  (i_setpoint_operate_select),
        .o_active  (lat_active),
        .o_wr_copy ()
    );

    bmmr_setpoint_reg #(.RESET_VALUE(`BMMR_RST_REFERENCE)) u_reference (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_wr      (wr_reference),
        .i_wr_sel  (i_setpoint_write_select),
        .i_wr_data (i_cmd_data),
        .i_op_sel  (i_setpoint_operate_select),
        .o_active  (ref_active),
        .o_wr_copy (ref_wr_copy)
    );

    bmmr_setpoint_reg #(.RESET_VALUE(`BMMR_RST_REFRESH_MASK)) u_mask (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_wr      (wr_mask),
        .i_wr_sel  (i_setpoint_write_select),
        .i_wr_data (i_cmd_data),
        .i_op_sel  (i_setpoint_operate_select),
        .o_active  (mask_active),
        .o_wr_copy ()
    );

    bmmr_setpoint_reg #(.RESET_VALUE(`BMMR_RST_TERMINATION)) u_term (
        .i_ref_clk (i_ref_clk),
        .i_rst_b   (i_rst_b),
        .i_wr      (wr_termination),
        .i_wr_sel  (i_setpoint_write_select),
        .i_wr_data (i_cmd_data),
        .i_op_sel  (i_setpoint_operate_select),
        .o_active  (term_active),
        .o_wr_copy ()
    );

    // ************************************************************
    // write leveling state
    // ************************************************************
    // held apart from the copies so a set-point switch cannot end it
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            write_leveling <= 1'b0;
        end else if (wr_latency) begin
            write_leveling <= i_cmd_data[`BMMR_LAT_LEVEL_BIT];
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_write_leveling <= 1'b0;
            o_cmd_ignored    <= 1'b0;
        end else begin
            o_write_leveling <= write_leveling;
            o_cmd_ignored    <= i_cmd_valid && !cmd_accept;
        end
    end

    // ************************************************************
    // register read
    // ************************************************************
    bmmr_byte_t config_value;
    bmmr_byte_t next_rd_data;

    assign config_value = {`BMMR_CFG_WIDTH, `BMMR_CFG_DENSITY,
                           `BMMR_CFG_TYPE};

    always_comb begin
        next_rd_data = `BMMR_RD_UNDEFINED;
        if (hit_config) begin
            next_rd_data = config_value;
        end else if (hit_reference) begin
            next_rd_data = ref_wr_copy;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_rd_valid <= 1'b0;
            o_rd_data  <= `BMMR_RD_UNDEFINED;
        end else begin
            o_rd_valid <= cmd_rd;
            if (cmd_rd) begin
                o_rd_data <= next_rd_data;
            end
        end
    end

    // ************************************************************
    // latency decode from the active copy
    // ************************************************************
    bmmr_code_t rl_code;
    bmmr_code_t wl_code;
    logic [7:0] next_read_latency;
    logic [7:0] next_rtp;
    logic [7:0] next_write_latency;
    logic [63:0] rl_plain_tbl;
    logic [63:0] rl_inv_tbl;
    logic [63:0] rtp_tbl;
    logic [63:0] wl_a_tbl;
    logic [63:0] wl_b_tbl;

    assign rl_plain_tbl = `BMMR_RL_PLAIN;
    assign rl_inv_tbl   = `BMMR_RL_INV;
    assign rtp_tbl      = `BMMR_RTP;
    assign wl_a_tbl     = `BMMR_WL_SET_A;
    assign wl_b_tbl     = `BMMR_WL_SET_B;

    assign rl_code = lat_active[`BMMR_LAT_RL_LSB +: 3];
    assign wl_code = lat_active[`BMMR_LAT_WL_LSB +: 3];

    always_comb begin
        next_rtp = rtp_tbl[rl_code * `BMMR_TBL_ENTRY +: 8];
        if (i_read_bus_inversion) begin
            next_read_latency =
                rl_inv_tbl[rl_code * `BMMR_TBL_ENTRY +: 8];
        end else begin
            next_read_latency =
                rl_plain_tbl[rl_code * `BMMR_TBL_ENTRY +: 8];
        end
        if (i_burst_32) begin
            next_rtp = next_rtp + `BMMR_RTP_BL32_ADD;
        end
    end

    always_comb begin
        if (lat_active[`BMMR_LAT_WLS_BIT]) begin
            next_write_latency =
                wl_b_tbl[wl_code * `BMMR_TBL_ENTRY +: 8];
        end else begin
            next_write_latency =
                wl_a_tbl[wl_code * `BMMR_TBL_ENTRY +: 8];
        end
    end

    // reset values equal code zero of each table
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_read_latency            <= rl_plain_tbl[7:0];
            o_read_to_precharge_delay <= rtp_tbl[7:0];
            o_write_latency           <= wl_a_tbl[7:0];
        end else begin
            o_read_latency            <= next_read_latency;
            o_read_to_precharge_delay <= next_rtp;
            o_write_latency           <= next_write_latency;
        end
    end

    // ************************************************************
    // command reference outputs
    // ************************************************************
    localparam bmmr_byte_t ref_rst = `BMMR_RST_REFERENCE;

    // reserved level codes are passed on unchanged
    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_command_reference_level  <= ref_rst[`BMMR_REF_LEVEL_LSB +: 6];
            o_command_reference_range  <= ref_rst[`BMMR_REF_RANGE_BIT];
            o_command_training_variant <= ref_rst[`BMMR_REF_VARIANT_BIT];
        end else begin
            o_command_reference_level  <=
                ref_active[`BMMR_REF_LEVEL_LSB +: 6];
            o_command_reference_range  <=
                ref_active[`BMMR_REF_RANGE_BIT];
            o_command_training_variant <=
                ref_active[`BMMR_REF_VARIANT_BIT];
        end
    end

    // ************************************************************
    // partial array refresh
    // ************************************************************
    logic [2:0] segment;

    // 2Gb and 3Gb have no segment map; they share the 4Gb bits
    always_comb begin
        unique case (`BMMR_CFG_DENSITY)
            `BMMR_DENS_6GB,
            `BMMR_DENS_8GB:  segment =
                i_refresh_row[`BMMR_SEG_LSB_MID +: 3];
            `BMMR_DENS_12GB,
            `BMMR_DENS_16GB: segment =
                i_refresh_row[`BMMR_SEG_LSB_LARGE +: 3];
            default:         segment =
                i_refresh_row[`BMMR_SEG_LSB_SMALL +: 3];
        endcase
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_partial_array_refresh <= `BMMR_RST_REFRESH_MASK;
            o_refresh_row_skipped   <= 1'b0;
        end else begin
            o_partial_array_refresh <= mask_active;
            o_refresh_row_skipped   <= mask_active[segment];
        end
    end

    // ************************************************************
    // command bus termination
    // ************************************************************
    bmmr_term_t own_off;
    bmmr_term_t next_lower;
    bmmr_term_t next_upper;

    // no power state input: termination never drops in low power
    assign own_off = {term_active[`BMMR_TERM_CA_BIT],
                      term_active[`BMMR_TERM_CS_BIT],
                      term_active[`BMMR_TERM_CK_BIT]};

    always_comb begin
        next_lower = i_termination_settings & ~own_off;
        next_upper = i_termination_settings & ~own_off;
        if (term_active[`BMMR_TERM_LOWER_BIT]) begin
            next_lower = '0;
        end
        if (term_active[`BMMR_TERM_UPPER_BIT]) begin
            next_upper = '0;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            o_host_termination_value <= '0;
            o_lower_byte_termination <= '0;
            o_upper_byte_termination <= '0;
        end else begin
            // reserved code seven is passed on as written
            o_host_termination_value <=
                term_active[`BMMR_TERM_HOST_LSB +: 3];
            o_lower_byte_termination <= next_lower;
            o_upper_byte_termination <= next_upper;
        end
    end
endmodule
`default_nettype wire

/* File: rtl/bmmr_setpoint_reg.sv */
`timescale 1ns/1ps
`default_nettype none
// two set-point copies of one 8-bit register
module bmmr_setpoint_reg #(
    parameter logic [7:0] RESET_VALUE = 8'h00
) (
    // clock and reset
    input  wire logic       i_ref_clk,
    input  wire logic       i_rst_b,
    // write side
    input  wire logic       i_wr,
    input  wire logic       i_wr_sel,
    input  wire logic [7:0] i_wr_data,
    // read side
    input  wire logic       i_op_sel,
    output logic      [7:0] o_active,
    output logic      [7:0] o_wr_copy
);
    logic [7:0] copy [0:1];

    always_ff @(posedge i_ref_clk) begin
        if (!i_rst_b) begin
            copy[0] <= RESET_VALUE;
            copy[1] <= RESET_VALUE;
        end else if (i_wr) begin
            copy[i_wr_sel] <= i_wr_data;
        end
    end

    assign o_active  = copy[i_op_sel];
    assign o_wr_copy = copy[i_wr_sel];
endmodule
`default_nettype wire

/* File: test/bmmr_bank_properties.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bmmr_regs.svh"
// ********
// port checker
// ********
module bmmr_bank_properties (
    // clock and reset
    input wire logic                 i_ref_clk,
    input wire logic                 i_rst_b,
    // command side
    input wire logic                 i_cmd_valid,
    input wire logic                 i_cmd_write,
    input wire bmmr_pkg::bmmr_addr_t i_cmd_addr,
    input wire bmmr_pkg::bmmr_byte_t i_cmd_data,
    input wire logic                 i_burst_32,
    input wire bmmr_pkg::bmmr_term_t i_termination_settings,
    input wire logic [17:0]          i_refresh_row,
    // answers and state
    input wire logic                 o_rd_valid,
    input wire bmmr_pkg::bmmr_byte_t o_rd_data,
    input wire logic                 o_cmd_ignored,
    input wire logic                 o_write_leveling,
    input wire logic [7:0]           o_read_to_precharge_delay,
    input wire bmmr_pkg::bmmr_byte_t o_partial_array_refresh,
    input wire logic                 o_refresh_row_skipped,
    input wire bmmr_pkg::bmmr_term_t o_lower_byte_termination,
    input wire bmmr_pkg::bmmr_term_t o_upper_byte_termination
);
    import bmmr_pkg::*;
    logic lat_wr;
    assign lat_wr = i_cmd_valid && i_cmd_write
                    && i_cmd_addr == `BMMR_ADDR_LATENCY;
    default clocking @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);
    chk_read_answer: assert property (
        i_cmd_valid && !i_cmd_write |=> o_rd_valid != o_cmd_ignored)
        else $error("read got no single answer");
    chk_read_cause: assert property (
        o_rd_valid |-> $past(i_cmd_valid && !i_cmd_write))
        else $error("read answer without read");
    chk_ignore_cause: assert property (
        o_cmd_ignored |-> $past(i_cmd_valid) && !$past(lat_wr))
        else $error("latency write refused");
    chk_level_set: assert property (
        lat_wr |-> ##2 o_write_leveling == $past(i_cmd_data[7], 2))
        else $error("leveling not taken from bit 7");
    // the flag lags the write by two edges, hence the past term
    chk_level_hold: assert property (
        !$past(lat_wr) |=> $stable(o_write_leveling))
        else $error("leveling moved without latency write");
    chk_rtp_burst: assert property (
        $past(i_burst_32) ? o_read_to_precharge_delay inside {[16:24]}
                          : o_read_to_precharge_delay inside {[8:16]})
        else $error("precharge delay ignores burst length");
    chk_config_read: assert property (
        o_rd_valid && $past(i_cmd_addr) == `BMMR_ADDR_CONFIG
        |-> o_rd_data == 8'h58)
        else $error("configuration content wrong");
    chk_wo_read: assert property (
        o_rd_valid && $past(i_cmd_addr) inside {`BMMR_ADDR_LATENCY,
        `BMMR_ADDR_REFRESH_MASK, `BMMR_ADDR_TERMINATION}
        |-> o_rd_data == 8'h00)
        else $error("write-only read not 00");
    chk_rd_hold: assert property (
        !o_rd_valid |-> $stable(o_rd_data))
        else $error("read data moved without read");
    chk_term_gate: assert property (
        ((o_lower_byte_termination | o_upper_byte_termination)
        & ~$past(i_termination_settings)) == 3'b000)
        else $error("termination on without enable");
    chk_skip_mask: assert property (
        o_refresh_row_skipped
        == o_partial_array_refresh[$past(i_refresh_row[16:14])])
        else $error("skip flag not mask bit of segment");
endmodule
bind bmmr_bank bmmr_bank_properties chk_u (
    .i_ref_clk, .i_rst_b, .i_cmd_valid, .i_cmd_write, .i_cmd_addr,
    .i_cmd_data, .i_burst_32, .i_termination_settings, .i_refresh_row,
    .o_rd_valid, .o_rd_data, .o_cmd_ignored, .o_write_leveling,
    .o_read_to_precharge_delay, .o_partial_array_refresh,
    .o_refresh_row_skipped, .o_lower_byte_termination,
    .o_upper_byte_termination
);
`default_nettype wire

/* File: test/bmmr_bank_test.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bmmr_regs.svh"
// ********
// register bank bench
// ********
module bmmr_bank_test;
    import bmmr_pkg::*;
    logic        i_ref_clk, i_rst_b, i_cmd_valid, i_cmd_write;
    bmmr_addr_t  i_cmd_addr;
    bmmr_byte_t  i_cmd_data, o_rd_data, o_partial_array_refresh;
    logic        o_rd_valid, o_cmd_ignored, i_setpoint_write_select;
    logic        i_setpoint_operate_select, i_read_bus_inversion;
    logic        i_burst_32, o_write_leveling, o_command_reference_range;
    bmmr_term_t  i_termination_settings, o_host_termination_value;
    bmmr_term_t  o_lower_byte_termination, o_upper_byte_termination;
    logic [17:0] i_refresh_row;
    logic [7:0]  o_read_latency, o_read_to_precharge_delay, o_write_latency;
    logic [5:0]  o_command_reference_level;
    logic        o_command_training_variant, o_refresh_row_skipped;
    int          errors, cmp_count, s, c;
    localparam bmmr_byte_t rl_a [8] = '{8'h06, 8'h0a, 8'h10, 8'h16,
                                         8'h1a, 8'h20, 8'h24, 8'h28};
    localparam bmmr_byte_t rl_b [8] = '{8'h06, 8'h0c, 8'h12, 8'h18,
                                         8'h1e, 8'h24, 8'h28, 8'h2c};
    localparam bmmr_byte_t rtp [8] = '{8'h08, 8'h08, 8'h08, 8'h08,
                                        8'h0a, 8'h0c, 8'h0e, 8'h10};
    localparam bmmr_byte_t wl_a [8] = '{8'h04, 8'h06, 8'h08, 8'h0a,
                                         8'h0c, 8'h0e, 8'h10, 8'h12};
    localparam bmmr_byte_t wl_b [8] = '{8'h04, 8'h08, 8'h0c, 8'h12,
                                         8'h16, 8'h1a, 8'h1e, 8'h22};
    wire bmmr_byte_t ref_out = {o_command_training_variant,
        o_command_reference_range, o_command_reference_level};
    wire bmmr_byte_t term_out = {2'b00, o_lower_byte_termination,
        o_upper_byte_termination};
    bmmr_bank dut_u (
        .i_ref_clk, .i_rst_b, .i_cmd_valid, .i_cmd_write, .i_cmd_addr,
        .i_cmd_data, .o_rd_valid, .o_rd_data, .o_cmd_ignored,
        .i_setpoint_write_select, .i_setpoint_operate_select,
        .i_read_bus_inversion, .i_burst_32, .i_termination_settings,
        .i_refresh_row, .o_read_latency, .o_read_to_precharge_delay,
        .o_write_latency, .o_write_leveling, .o_command_reference_level,
        .o_command_reference_range, .o_command_training_variant,
        .o_partial_array_refresh, .o_refresh_row_skipped,
        .o_host_termination_value, .o_lower_byte_termination,
        .o_upper_byte_termination
    );
    bmmr_ctrl_model ctl_u (
        .i_ref_clk, .o_cmd_valid(i_cmd_valid), .o_cmd_write(i_cmd_write),
        .o_cmd_addr(i_cmd_addr), .o_cmd_data(i_cmd_data),
        .i_rd_valid(o_rd_valid), .i_rd_data(o_rd_data),
        .i_cmd_ignored(o_cmd_ignored)
    );
    task automatic chk(input string nm, input logic [7:0] seen, exp);
        cmp_count++;
        if (seen !== exp) begin
            errors++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic wait_cy(input int n);
        repeat (n) @(negedge i_ref_clk);
    endtask
    // two edges: copy first, then the output register
    task automatic wr(input bmmr_addr_t a, input bmmr_byte_t d);
        ctl_u.send(1'b1, a, d);
        wait_cy(2);
    endtask
    task automatic rd_chk(input string nm, input bmmr_addr_t a,
                          input bmmr_byte_t exp);
        ctl_u.send(1'b0, a, 8'h00);
        chk(nm, (o_rd_valid === 1'b1) ? o_rd_data : 8'hee, exp);
    endtask
    task automatic close_out;
        if (errors == 0 && cmp_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    initial begin
        i_ref_clk = 1'b0;
        forever #12.5 i_ref_clk = ~i_ref_clk;
    end
    initial begin
        #(25 * 5000);
        errors++;
        close_out();
    end
    initial begin
        {i_rst_b, i_setpoint_write_select, i_setpoint_operate_select} = '0;
        {i_read_bus_inversion, i_burst_32, i_termination_settings} = '0;
        i_refresh_row = 18'h0_0000;
        wait_cy(20);
        i_rst_b = 1'b1;
        wait_cy(1);
        chk("rl_rst", o_read_latency, 8'h06);
        chk("wl_rst", o_write_latency, 8'h04);
        chk("ref_rst", ref_out, 8'h40);
        chk("mask_rst", o_partial_array_refresh, 8'h00);
        for (s = 0; s < 2; s++) begin
            for (c = 0; c < 8; c++) begin
                i_read_bus_inversion = s[0];
                wr(`BMMR_ADDR_LATENCY, {1'b0, s[0], c[2:0], c[2:0]});
                chk("rl", o_read_latency,
                    s ? rl_b[c] : rl_a[c]);
                chk("rtp", o_read_to_precharge_delay, rtp[c]);
                chk("wl", o_write_latency,
                    s ? wl_b[c] : wl_a[c]);
            end
        end
        i_burst_32 = 1'b1;
        wait_cy(2);
        chk("rtp32", o_read_to_precharge_delay, 8'h18);
        i_burst_32 = 1'b0;
        i_setpoint_write_select = 1'b1;
        wr(`BMMR_ADDR_REFERENCE, 8'hb2);
        rd_chk("ref_w1", `BMMR_ADDR_REFERENCE, 8'hb2);
        i_setpoint_write_select = 1'b0;
        rd_chk("ref_w0", `BMMR_ADDR_REFERENCE, 8'h40);
        chk("ref_op0", ref_out, 8'h40);
        i_setpoint_operate_select = 1'b1;
        wait_cy(2);
        chk("ref_op1", ref_out, 8'hb2);
        wr(`BMMR_ADDR_REFERENCE, 8'h32);
        chk("ref_idle", ref_out, 8'hb2);
        rd_chk("cfg", `BMMR_ADDR_CONFIG, 8'h58);
        wr(`BMMR_ADDR_CONFIG, 8'h00);
        rd_chk("cfg_ro", `BMMR_ADDR_CONFIG, 8'h58);
        rd_chk("lat_wo", `BMMR_ADDR_LATENCY, 8'h00);
        rd_chk("unmapped", 6'h3f, 8'h00);
        i_setpoint_write_select = 1'b1;
        wr(`BMMR_ADDR_REFRESH_MASK, 8'h81);
        chk("mask", o_partial_array_refresh, 8'h81);
        for (c = 0; c < 8; c++) begin
            i_refresh_row = {1'b1, c[2:0], 14'h2aaa};
            wait_cy(2);
            chk("skip", {7'h00, o_refresh_row_skipped},
                {7'h00, c == 0 || c == 7});
        end
        // termination programmed before its enables are raised
        wr(`BMMR_ADDR_TERMINATION, 8'h4c);
        i_termination_settings = 3'b111;
        wait_cy(2);
        chk("host", {5'h00, o_host_termination_value}, 8'h04);
        chk("term_lo_off", term_out, 8'h06);
        wr(`BMMR_ADDR_TERMINATION, 8'h30);
        chk("term_cs_ca", term_out, 8'h09);
        i_termination_settings = 3'b010;
        wr(`BMMR_ADDR_TERMINATION, 8'h00);
        chk("term_follow", term_out, 8'h12);
        wr(`BMMR_ADDR_LATENCY, 8'h80);
        chk("level_on", {7'h00, o_write_leveling}, 8'h01);
        ctl_u.send(1'b0, `BMMR_ADDR_REFERENCE, 8'h00);
        chk("ignored", {6'h00, o_cmd_ignored, o_rd_valid}, 8'h02);
        wr(`BMMR_ADDR_REFERENCE, 8'h11);
        wr(`BMMR_ADDR_LATENCY, 8'h00);
        chk("level_off", {7'h00, o_write_leveling}, 8'h00);
        rd_chk("ref_kept", `BMMR_ADDR_REFERENCE, 8'hb2);
        i_rst_b = 1'b0;
        wait_cy(3);
        i_rst_b = 1'b1;
        wait_cy(1);
        chk("ref_rst2", ref_out, 8'h40);
        close_out();
    end
endmodule
`default_nettype wire

/* File: test/bmmr_ctrl_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ********
// controller model
// ********
module bmmr_ctrl_model (
    // clock
    input  wire logic                 i_ref_clk,
    // command strobe and fields
    output logic                      o_cmd_valid,
    output logic                      o_cmd_write,
    output bmmr_pkg::bmmr_addr_t      o_cmd_addr,
    output bmmr_pkg::bmmr_byte_t      o_cmd_data,
    // answers
    input  wire logic                 i_rd_valid,
    input  wire bmmr_pkg::bmmr_byte_t i_rd_data,
    input  wire logic                 i_cmd_ignored
);
    import bmmr_pkg::*;
    initial begin
        o_cmd_valid = 1'b0;
        o_cmd_write = 1'b0;
        o_cmd_addr  = 6'h3f;
        o_cmd_data  = 8'h00;
    end
    // fields flip once released so a stale command never looks valid
    task automatic send(input logic w, input bmmr_addr_t a,
                        input bmmr_byte_t d);
        @(negedge i_ref_clk);
        o_cmd_valid = 1'b1;
        o_cmd_write = w;
        o_cmd_addr  = a;
        o_cmd_data  = d;
        @(negedge i_ref_clk);
        o_cmd_valid = 1'b0;
        o_cmd_write = ~w;
        o_cmd_addr  = ~a;
        o_cmd_data  = ~d;
    endtask
endmodule
`default_nettype wire
